/* rtl/aewb_core.sv */
// module: auto exposure, auto gain and white balance control with AXI4-Lite
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module aewb_core
  import aewb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire aewb_axi_req_t bus_i,
  output aewb_axi_rsp_t bus_o,
  input wire logic frame_done_i,
  input wire logic [11:0] luma_i,
  input wire aewb_rgb_t wb_avg_i,
  output logic [7:0] analog_gain_o,
  output logic [7:0] digital_gain_o,
  output logic [23:0] exposure_o,
  output aewb_rgb_t wb_gain_o,
  output aewb_region_t wb_region_o
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic automatic_gain_control;
    logic ae;
    logic gsel;
    aewb_depth_t depth;
    aewb_wb_mode_t method;
    logic [1:0] csel;
    logic [7:0] again;
    logic [7:0] dgain;
    logic [7:0] gfloor;
    logic [7:0] gceil;
    logic [23:0] exp;
    logic [23:0] sfloor;
    logic [23:0] sceil;
    logic [7:0] target;
    aewb_region_t reg_wb;
    logic [2:0][7:0] man;
    logic [2:0][2:0][7:0] pre;
    logic [2:0][7:0] wbg;
    logic [11:0] luma;
    logic awh;
    logic wh;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awrdy;
    logic wrdy;
    logic bv;
    logic [1:0] bresp;
    logic arrdy;
    logic rv;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aewb_state_t;

  aewb_state_t q;
  aewb_state_t d;
  logic [11:0] tgt;
  logic dark;
  logic bright;
  logic wr_go;
  logic werr;
  logic [31:0] wnv;

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [11:0] scale_tgt(logic [7:0] t,
                                            aewb_depth_t dp);
    case (dp)
      DEPTH_10: return {2'h0, t, 2'h0};
      DEPTH_12: return {t, 4'h0};
      default: return {4'h0, t};
    endcase
  endfunction : scale_tgt

  function automatic logic [1:0] pre_idx(aewb_wb_mode_t m);
    case (m)
      WB_PRE1: return 2'h1;
      WB_PRE2: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction : pre_idx

  function automatic logic is_pre(aewb_wb_mode_t m);
    return (m == WB_PRE0) || (m == WB_PRE1) || (m == WB_PRE2);
  endfunction : is_pre

  function automatic logic [7:0] clamp8(logic [7:0] v, logic [7:0] lo,
                                        logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  function automatic logic [23:0] clamp24(logic [23:0] v,
                                          logic [23:0] lo,
                                          logic [23:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp24

  function automatic logic exp_ok(logic [31:0] w);
    return (w != 32'h0) && (w <= EXP_MAX);
  endfunction : exp_ok

  // colour gains: green is the reference, red and blue lift to it
  function automatic logic [2:0][7:0] wb_calc(aewb_rgb_t a);
    logic [2:0][7:0] g;
    g[0] = (a.green > a.red) ? a.green - a.red : 8'h00;
    g[1] = 8'h00;
    g[2] = (a.green > a.blue) ? a.green - a.blue : 8'h00;
    return g;
  endfunction : wb_calc

  function automatic logic [31:0] rd_word(aewb_state_t v,
                                          logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a[7:2])
      IDX_CTRL: begin
        r[CTRL_AGC] = v.automatic_gain_control;
        r[CTRL_AE] = v.ae;
        r[CTRL_GSEL] = v.gsel;
        r[CTRL_WB +: 3] = v.method;
        r[CTRL_DEP +: 2] = v.depth;
      end
      IDX_GAIN: r[7:0] = v.gsel ? v.dgain : v.again;
      IDX_GFLOOR: r[7:0] = v.gfloor;
      IDX_GCEIL: r[7:0] = v.gceil;
      IDX_EXPO: r[23:0] = v.exp;
      IDX_SFLOOR: r[23:0] = v.sfloor;
      IDX_SCEIL: r[23:0] = v.sceil;
      IDX_TARGET: r[7:0] = v.target;
      IDX_CSEL: r[1:0] = v.csel;
      IDX_CVAL: begin
        if (is_pre(v.method)) begin
          r[7:0] = v.pre[pre_idx(v.method)][v.csel];
        end else begin
          r[7:0] = v.man[v.csel];
        end
      end
      IDX_WB_LEFT: r[10:0] = v.reg_wb.left;
      IDX_WB_TOP: r[10:0] = v.reg_wb.top;
      IDX_WB_WIDTH: r[10:0] = v.reg_wb.width;
      IDX_WB_HEIGHT: r[10:0] = v.reg_wb.height;
      IDX_STATUS: begin
        r[11:0] = v.luma;
        r[STAT_TGT +: 12] = scale_tgt(v.target, v.depth);
      end
      default: ;
    endcase
    return r;
  endfunction : rd_word

  // byte lanes without a strobe keep the old content
  function automatic logic [31:0] wmerge(logic [31:0] o,
                                         logic [31:0] n,
                                         logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction : wmerge

  // brightness compare against the depth-scaled target
  assign tgt = scale_tgt(q.target, q.depth); // see RULE24
  assign dark = luma_i < tgt;
  assign bright = luma_i > tgt;
  assign wr_go = q.awh && q.wh && !q.bv;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    d = q;
    werr = 1'h0;
    wnv = wmerge(rd_word(q, q.awa), q.wd, q.ws);
    // read channel: one read in flight, answer one cycle later
    if (q.rv && bus_i.rready) d.rv = 1'h0;
    if (bus_i.arvalid && q.arrdy) begin
      d.rv = 1'h1;
      d.rdata = rd_word(q, bus_i.araddr);
      d.rresp = (bus_i.araddr[7:2] <= IDX_STATUS) ? RESP_OKAY
                                                  : RESP_SLVERR;
    end
    d.arrdy = !d.rv;
    // write channels: address and data caught in any order
    if (q.bv && bus_i.bready) d.bv = 1'h0;
    if (bus_i.awvalid && q.awrdy) begin
      d.awh = 1'h1;
      d.awa = bus_i.awaddr;
    end
    if (bus_i.wvalid && q.wrdy) begin
      d.wh = 1'h1;
      d.wd = bus_i.wdata;
      d.ws = bus_i.wstrb;
    end
    // out-of-range values are refused whole and answered SLVERR
    if (wr_go) begin
      d.awh = 1'h0;
      d.wh = 1'h0;
      d.bv = 1'h1;
      case (q.awa[7:2])
        IDX_CTRL: begin
          if (wnv[CTRL_WB +: 3] > WB_LAST ||
              wnv[CTRL_DEP +: 2] > DEPTH_LAST) begin
            werr = 1'h1; // see RULE14
          end else begin
            d.automatic_gain_control = wnv[CTRL_AGC]; // see RULE6
            d.ae = wnv[CTRL_AE]; // see RULE11
            d.gsel = wnv[CTRL_GSEL]; // see RULE3
            d.method = aewb_wb_mode_t'(wnv[CTRL_WB +: 3]);
            d.depth = aewb_depth_t'(wnv[CTRL_DEP +: 2]);
          end
        end
        IDX_GAIN: begin
          if (q.gsel) begin
            if (|wnv[31:8]) werr = 1'h1; // see RULE4
            else d.dgain = wnv[7:0];
          end else if (q.automatic_gain_control || wnv > A_GAIN_MAX) begin
            werr = 1'h1; // see RULE5
          end else begin
            d.again = wnv[7:0]; // see RULE4
          end
        end
        IDX_GFLOOR: begin
          if (wnv > {24'h0, q.gceil}) werr = 1'h1; // see RULE7
          else d.gfloor = wnv[7:0];
        end
        IDX_GCEIL: begin
          if (wnv > A_GAIN_MAX || wnv < {24'h0, q.gfloor}) begin
            werr = 1'h1; // see RULE8
          end else begin
            d.gceil = wnv[7:0];
          end
        end
        IDX_EXPO: begin
          if (!exp_ok(wnv)) werr = 1'h1;
          else d.exp = wnv[23:0];
        end
        IDX_SFLOOR: begin
          if (!exp_ok(wnv) || wnv > {8'h0, q.sceil}) begin
            werr = 1'h1; // see RULE12
          end else begin
            d.sfloor = wnv[23:0];
          end
        end
        IDX_SCEIL: begin
          if (!exp_ok(wnv) || wnv < {8'h0, q.sfloor}) begin
            werr = 1'h1; // see RULE12
          end else begin
            d.sceil = wnv[23:0];
          end
        end
        IDX_TARGET: begin
          if (|wnv[31:8]) werr = 1'h1;
          else d.target = wnv[7:0]; // see RULE24
        end
        IDX_CSEL: begin
          if (wnv > CSEL_MAX) werr = 1'h1; // see RULE13
          else d.csel = wnv[1:0];
        end
        IDX_CVAL: begin
          if (|wnv[31:8]) begin
            werr = 1'h1; // see RULE13
          end else if (is_pre(q.method)) begin
            d.pre[pre_idx(q.method)][q.csel] = wnv[7:0]; // see RULE18
          end else begin
            d.man[q.csel] = wnv[7:0];
          end
        end
        IDX_WB_LEFT: begin
          if (wnv > WB_L_MAX) werr = 1'h1; // see RULE20
          else d.reg_wb.left = wnv[10:0];
        end
        IDX_WB_TOP: begin
          if (wnv > WB_T_MAX) werr = 1'h1; // see RULE20
          else d.reg_wb.top = wnv[10:0];
        end
        IDX_WB_WIDTH: begin
          if (wnv == 32'h0 || wnv > WB_W_MAX) werr = 1'h1; // see RULE19
          else d.reg_wb.width = wnv[10:0];
        end
        IDX_WB_HEIGHT: begin
          if (wnv == 32'h0 || wnv > WB_H_MAX) werr = 1'h1; // see RULE19
          else d.reg_wb.height = wnv[10:0];
        end
        default: werr = 1'h1; // status is read-only, rest unmapped
      endcase
      d.bresp = werr ? RESP_SLVERR : RESP_OKAY;
    end
    d.awrdy = !d.awh && !d.bv;
    d.wrdy = !d.wh && !d.bv;
    // one brightness step per finished frame, exposure before gain
    if (frame_done_i) begin
      d.luma = luma_i; // see RULE25
      if (dark) begin
        if (d.ae && d.exp < d.sceil) begin
          d.exp = (d.sceil - d.exp > EXP_STEP) ? d.exp + EXP_STEP
                                               : d.sceil; // see RULE9
        end else if (d.automatic_gain_control) begin
          d.again = (d.again < d.gceil) ? d.again + GAIN_STEP
                                        : d.gceil; // see RULE1 RULE23
        end
      end else if (bright) begin
        if (d.ae && d.exp > d.sfloor) begin
          d.exp = (d.exp - d.sfloor > EXP_STEP) ? d.exp - EXP_STEP
                                                : d.sfloor; // see RULE10
        end else if (d.automatic_gain_control) begin
          d.again = (d.again > d.gfloor) ? d.again - GAIN_STEP
                                         : d.gfloor; // see RULE2
        end
      end
      // a limit moved below the current value pulls it back in
      if (d.ae) d.exp = clamp24(d.exp, d.sfloor, d.sceil); // see RULE25
      if (d.automatic_gain_control) d.again = clamp8(d.again, d.gfloor, d.gceil);
      case (d.method)
        WB_CONT: d.wbg = wb_calc(wb_avg_i); // see RULE16
        WB_ONCE: begin
          d.man = wb_calc(wb_avg_i); // see RULE17
          d.method = WB_OFF;
        end
        default: ;
      endcase
    end
    // applied colour gains; continuous keeps its last result
    case (d.method)
      WB_OFF, WB_ONCE: d.wbg = d.man; // see RULE15
      WB_PRE0, WB_PRE1, WB_PRE2: d.wbg = d.pre[pre_idx(d.method)];
      default: ;
    endcase
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0; // switches off, analog selected, method off
      q.gceil <= A_GAIN_MAX8;
      q.exp <= EXP_RST;
      q.sfloor <= SFLOOR_RST;
      q.sceil <= SCEIL_RST;
      q.target <= TARGET_RST;
      q.reg_wb.width <= WB_W_RST;
      q.reg_wb.height <= WB_H_RST;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign bus_o = '{awready: q.awrdy, wready: q.wrdy, bvalid: q.bv,
                   bresp: q.bresp, arready: q.arrdy, rvalid: q.rv,
                   rdata: q.rdata, rresp: q.rresp};
  assign analog_gain_o = q.again;
  assign digital_gain_o = q.dgain;
  assign exposure_o = q.exp;
  assign wb_gain_o = '{red: q.wbg[0], green: q.wbg[1], blue: q.wbg[2]};
  assign wb_region_o = q.reg_wb;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_gain_ceiling: assert property ( // see RULE1
    frame_done_i && clk_en_i && q.automatic_gain_control && !wr_go |=> q.again <= q.gceil)
    else $error("gain above ceiling after frame step");

  chk_gain_raise: assert property ( // see RULE1
    frame_done_i && clk_en_i && q.automatic_gain_control && !q.ae && dark && !wr_go &&
    q.again < q.gceil && q.again >= q.gfloor
    |=> q.again == $past(q.again) + GAIN_STEP)
    else $error("dark frame did not raise gain by one");

  chk_gain_lower: assert property ( // see RULE2
    frame_done_i && clk_en_i && q.automatic_gain_control && !q.ae && bright && !wr_go &&
    q.again > q.gfloor && q.again <= q.gceil
    |=> q.again == $past(q.again) - GAIN_STEP)
    else $error("bright frame did not lower gain by one");

  chk_agc_lock: assert property ( // see RULE5
    q.automatic_gain_control && !frame_done_i |=> $stable(q.again))
    else $error("analog gain moved outside a frame step");

  chk_gain_limits: assert property ( // see RULE7
    q.gfloor <= q.gceil && q.gceil <= A_GAIN_MAX8)
    else $error("gain floor above ceiling");

  chk_exp_limits: assert property ( // see RULE10
    frame_done_i && clk_en_i && q.ae && !wr_go
    |=> q.exp >= q.sfloor && q.exp <= q.sceil)
    else $error("exposure outside limits after frame step");

  chk_exp_first: assert property ( // see RULE23
    frame_done_i && clk_en_i && q.ae && q.automatic_gain_control && dark && !wr_go &&
    q.exp < q.sceil |=> $stable(q.again) && q.exp > $past(q.exp))
    else $error("gain moved while exposure had room");

  chk_once_off: assert property ( // see RULE17
    frame_done_i && clk_en_i && q.method == WB_ONCE && !wr_go
    |=> q.method == WB_OFF ##1 q.wbg == $past(q.man))
    else $error("one-shot balance did not store and return off");

endmodule : aewb_core

/* rtl/aewb_pkg.sv */
// package: register map, limits and types of the exposure/white balance block
// What this block does
// RULE1 - dark image raises gain up to ceiling
// RULE2 - bright image lowers the gain
// RULE3 - gain selector picks analog or digital
// RULE4 - analog gain 0..208, digital 0..255, both zero
// RULE5 - analog gain locked while auto gain on
// RULE6 - auto gain switch, comes up off
// RULE7 - gain floor 0..208, never above ceiling
// RULE8 - gain ceiling up to 208, never below floor
// RULE9 - dark image lengthens exposure up to ceiling
// RULE10 - bright image shortens exposure down to floor
// RULE11 - auto shutter switch, comes up off
// RULE12 - shutter limits 1..16777215 us, floor 14
// RULE13 - colour selector picks gain, values 0..255
// RULE14 - white balance methods, default off
// RULE15 - off applies programmed colour gains
// RULE16 - continuous recalculates gains every frame
// RULE17 - once calculates, stores gains, returns off
// RULE18 - three writable preset colour gain sets
// RULE19 - region width 1..1624, height 1..1240
// RULE20 - region offsets up to 1623 and 1239
// RULE21 - software sets regions, automation, target last
// RULE22 - show flat white before one-shot balance
// RULE23 - exposure corrects first, then gain
// RULE24 - target scaled by output depth
// RULE25 - one update per frame, clamped to limits
package aewb_pkg;

  // ********************************************************
  // register word indices (byte address is four times)
  // ********************************************************
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_GAIN = 6'h01;
  localparam logic [5:0] IDX_GFLOOR = 6'h02;
  localparam logic [5:0] IDX_GCEIL = 6'h03;
  localparam logic [5:0] IDX_EXPO = 6'h04;
  localparam logic [5:0] IDX_SFLOOR = 6'h05;
  localparam logic [5:0] IDX_SCEIL = 6'h06;
  localparam logic [5:0] IDX_TARGET = 6'h07;
  localparam logic [5:0] IDX_CSEL = 6'h08;
  localparam logic [5:0] IDX_CVAL = 6'h09;
  localparam logic [5:0] IDX_WB_LEFT = 6'h0a;
  localparam logic [5:0] IDX_WB_TOP = 6'h0b;
  localparam logic [5:0] IDX_WB_WIDTH = 6'h0c;
  localparam logic [5:0] IDX_WB_HEIGHT = 6'h0d;
  localparam logic [5:0] IDX_STATUS = 6'h0e;

  // control word fields
  localparam int CTRL_AGC = 0;
  localparam int CTRL_AE = 1;
  localparam int CTRL_GSEL = 2;
  localparam int CTRL_WB = 3;
  localparam int CTRL_DEP = 6;
  localparam int STAT_TGT = 16;

  // ********************************************************
  // limits and reset values
  // ********************************************************
  localparam logic [31:0] A_GAIN_MAX = 32'h0000_00d0; // 208
  localparam logic [7:0] A_GAIN_MAX8 = 8'hd0;
  localparam logic [31:0] EXP_MAX = 32'h00ff_ffff;
  localparam logic [23:0] SFLOOR_RST = 24'h00_000e; // 14 us
  localparam logic [23:0] SCEIL_RST = 24'h00_46f6; // 18166 us
  localparam logic [23:0] EXP_RST = 24'h00_46f6; // 18166 us
  localparam logic [7:0] TARGET_RST = 8'h80; // 128
  localparam logic [31:0] WB_W_MAX = 32'h0000_0658; // 1624
  localparam logic [31:0] WB_H_MAX = 32'h0000_04d8; // 1240
  localparam logic [31:0] WB_L_MAX = 32'h0000_0657; // 1623
  localparam logic [31:0] WB_T_MAX = 32'h0000_04d7; // 1239
  localparam logic [10:0] WB_W_RST = 11'h658;
  localparam logic [10:0] WB_H_RST = 11'h4d8;
  localparam logic [31:0] CSEL_MAX = 32'h0000_0002;
  localparam logic [23:0] EXP_STEP = 24'h00_0010; // 16 us per frame
  localparam logic [7:0] GAIN_STEP = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [2:0] {
    WB_OFF, WB_ONCE, WB_CONT, WB_PRE0, WB_PRE1, WB_PRE2
  } aewb_wb_mode_t;
  localparam logic [2:0] WB_LAST = 3'h5;
  typedef enum logic [1:0] {DEPTH_8, DEPTH_10, DEPTH_12} aewb_depth_t;
  localparam logic [1:0] DEPTH_LAST = 2'h2;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } aewb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aewb_axi_rsp_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } aewb_rgb_t;

  typedef struct packed {
    logic [10:0] left;
    logic [10:0] top;
    logic [10:0] width;
    logic [10:0] height;
  } aewb_region_t;

endpackage : aewb_pkg

/* testbench/tb.sv */
// testbench: register bus and frame stimulus for the exposure/white balance core
`timescale 1ns/10ps
module tb
  import aewb_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic clk_en_i = 1'b1;
  aewb_axi_req_t req = '0;
  aewb_axi_rsp_t rsp;
  logic frame_done = 1'b0;
  logic [11:0] luma = 12'h000;
  aewb_rgb_t avg = '0;
  logic [7:0] again;
  logic [7:0] dgain;
  logic [23:0] expo;
  aewb_rgb_t wbg;
  aewb_region_t wbr;
  logic [31:0] rdat;
  logic [1:0] rrsp;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [5:0] ri [13] = '{IDX_CTRL, IDX_GAIN, IDX_GFLOOR, IDX_GCEIL,
    IDX_EXPO, IDX_SFLOOR, IDX_SCEIL, IDX_TARGET, IDX_CSEL, IDX_WB_LEFT,
    IDX_WB_TOP, IDX_WB_WIDTH, IDX_WB_HEIGHT};
  logic [31:0] rv [13] = '{32'h0, 32'h0, 32'h0, 32'hd0, 32'h46f6, 32'he,
    32'h46f6, 32'h80, 32'h0, 32'h0, 32'h0, 32'h658, 32'h4d8};

  // ********************************************************
  // clock, watchdog and device
  // ********************************************************
  // 200 MHz clock
  always #2.5 core_clk_i = ~core_clk_i;

  // cut a hung handshake short; the full run needs far fewer cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  aewb_core i_dut (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .bus_i(req),
    .bus_o(rsp),
    .frame_done_i(frame_done),
    .luma_i(luma),
    .wb_avg_i(avg),
    .analog_gain_o(again),
    .digital_gain_o(dgain),
    .exposure_o(expo),
    .wb_gain_o(wbg),
    .wb_region_o(wbr)
  );

  // ********************************************************
  // tasks
  // ********************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  // one write; address and data offered together, each dropped when taken
  task automatic bus_wr(input logic [5:0] idx, input logic [31:0] d,
                        input logic [1:0] er, input logic [3:0] st = 4'hf);
    logic done;
    done = 1'b0;
    @(posedge core_clk_i);
    req.awaddr <= {idx, 2'b00};
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= st;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid === 1'b1) begin
        done = 1'b1;
        req.bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
      end
    end
    // let the new setting reach the registered outputs
    repeat (2) @(posedge core_clk_i);
  endtask : bus_wr

  task automatic bus_rd(input logic [5:0] idx);
    logic done;
    done = 1'b0;
    @(posedge core_clk_i);
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid === 1'b1) begin
        done = 1'b1;
        rdat = rsp.rdata;
        rrsp = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
  endtask : bus_rd

  task automatic rd_chk(input string nm, input logic [5:0] idx,
                        input logic [31:0] exp, input logic [1:0] er);
    bus_rd(idx);
    chk(nm, exp, rdat);
    chk("rresp", {30'h0, er}, {30'h0, rrsp});
  endtask : rd_chk

  // one end-of-frame pulse with its statistics
  task automatic frame(input logic [11:0] l, input aewb_rgb_t a);
    @(posedge core_clk_i);
    frame_done <= 1'b1;
    luma <= l;
    avg <= a;
    @(posedge core_clk_i);
    frame_done <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : frame

  task automatic chk_ae(input logic [7:0] g, input logic [23:0] e);
    chk("analog gain", {24'h0, g}, {24'h0, again});
    chk("exposure", {8'h0, e}, {8'h0, expo});
  endtask : chk_ae

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      rd_chk("reset", ri[i], rv[i], RESP_OKAY);
    end
    chk_ae(8'h00, 24'h46f6);
    // gain kinds and their ranges
    bus_wr(IDX_GAIN, 32'hd1, RESP_SLVERR);
    bus_wr(IDX_GAIN, 32'h94, RESP_OKAY);
    bus_wr(IDX_CTRL, 32'h4, RESP_OKAY);
    bus_wr(IDX_GAIN, 32'h100, RESP_SLVERR);
    bus_wr(IDX_GAIN, 32'hff, RESP_OKAY);
    chk("digital gain", 32'hff, {24'h0, dgain});
    chk("analog gain", 32'h94, {24'h0, again});
    bus_wr(IDX_CTRL, 32'h0, RESP_OKAY);
    rd_chk("gain", IDX_GAIN, 32'h94, RESP_OKAY);
    // floor and ceiling refuse to cross
    bus_wr(IDX_GFLOOR, 32'hd1, RESP_SLVERR);
    bus_wr(IDX_GFLOOR, 32'h64, RESP_OKAY);
    bus_wr(IDX_GCEIL, 32'h63, RESP_SLVERR);
    bus_wr(IDX_GCEIL, 32'hd1, RESP_SLVERR);
    bus_wr(IDX_GCEIL, 32'h96, RESP_OKAY);
    bus_wr(IDX_GFLOOR, 32'h97, RESP_SLVERR);
    rd_chk("floor", IDX_GFLOOR, 32'h64, RESP_OKAY);
    rd_chk("ceiling", IDX_GCEIL, 32'h96, RESP_OKAY);
    // auto gain alone
    bus_wr(IDX_CTRL, 32'h1, RESP_OKAY);
    bus_wr(IDX_GAIN, 32'h0a, RESP_SLVERR);
    frame(12'h010, '0);
    chk_ae(8'h95, 24'h46f6);
    frame(12'h010, '0);
    chk_ae(8'h96, 24'h46f6);
    frame(12'h010, '0);
    chk_ae(8'h96, 24'h46f6);
    frame(12'h0ff, '0);
    chk_ae(8'h95, 24'h46f6);
    // a frame pulse while the clock enable is low must change nothing
    clk_en_i <= 1'b0;
    frame(12'h010, '0);
    chk_ae(8'h95, 24'h46f6);
    clk_en_i <= 1'b1;
    // both automations: shutter moves first
    bus_wr(IDX_CTRL, 32'h3, RESP_OKAY);
    bus_wr(IDX_TARGET, 32'h80, RESP_OKAY);
    frame(12'h0ff, '0);
    chk_ae(8'h95, 24'h46e6);
    frame(12'h010, '0);
    chk_ae(8'h95, 24'h46f6);
    frame(12'h010, '0);
    chk_ae(8'h96, 24'h46f6);
    bus_wr(IDX_SFLOOR, 32'h0, RESP_SLVERR);
    bus_wr(IDX_SCEIL, 32'h0100_0000, RESP_SLVERR);
    bus_wr(IDX_SFLOOR, 32'h46e6, RESP_OKAY);
    bus_wr(IDX_SCEIL, 32'h46e5, RESP_SLVERR);
    frame(12'h0ff, '0);
    chk_ae(8'h96, 24'h46e6);
    frame(12'h0ff, '0);
    chk_ae(8'h95, 24'h46e6);
    // target scaled by output depth
    bus_wr(IDX_CTRL, 32'h83, RESP_OKAY);
    bus_rd(IDX_STATUS);
    chk("scaled target", 32'h800, {20'h0, rdat[27:16]});
    chk("last luma", 32'hff, {20'h0, rdat[11:0]});
    frame(12'h400, '0);
    chk_ae(8'h95, 24'h46f6);
    bus_wr(IDX_CTRL, 32'h42, RESP_OKAY);
    bus_rd(IDX_STATUS);
    chk("scaled target", 32'h200, {20'h0, rdat[27:16]});
    frame(12'h201, '0);
    chk_ae(8'h95, 24'h46e6);
    // white balance: manual gains, then continuous and one-shot
    bus_wr(IDX_CTRL, 32'h0, RESP_OKAY);
    bus_wr(IDX_EXPO, 32'h0, RESP_SLVERR);
    bus_wr(IDX_EXPO, 32'h1234, RESP_OKAY);
    chk("exposure", 32'h1234, {8'h0, expo});
    for (int c = 0; c < 3; c++) begin
      bus_wr(IDX_CSEL, 32'(c), RESP_OKAY);
      bus_wr(IDX_CVAL, 32'h0a + 32'(c), RESP_OKAY);
    end
    bus_wr(IDX_CSEL, 32'h3, RESP_SLVERR);
    bus_wr(IDX_CVAL, 32'h100, RESP_SLVERR);
    chk("wb gains", 32'h000a0b0c, {8'h0, wbg});
    bus_wr(IDX_CTRL, 32'h10, RESP_OKAY);
    frame(12'h080, '{8'h3c, 8'h64, 8'h5a});
    chk("wb gains", 32'h0028000a, {8'h0, wbg});
    frame(12'h080, '{8'h64, 8'h64, 8'h32});
    chk("wb gains", 32'h00000032, {8'h0, wbg});
    frame(12'h080, '{8'h46, 8'h64, 8'h64});
    bus_wr(IDX_CTRL, 32'h8, RESP_OKAY);
    frame(12'h080, '{8'h46, 8'h64, 8'h64});
    chk("wb gains", 32'h001e0000, {8'h0, wbg});
    rd_chk("control", IDX_CTRL, 32'h0, RESP_OKAY);
    bus_wr(IDX_CSEL, 32'h0, RESP_OKAY);
    rd_chk("red gain", IDX_CVAL, 32'h1e, RESP_OKAY);
    // presets keep their own gains
    bus_wr(IDX_CTRL, 32'h20, RESP_OKAY);
    bus_wr(IDX_CSEL, 32'h1, RESP_OKAY);
    bus_wr(IDX_CVAL, 32'h55, RESP_OKAY);
    chk("green gain", 32'h55, {24'h0, wbg.green});
    bus_wr(IDX_CTRL, 32'h18, RESP_OKAY);
    bus_wr(IDX_CTRL, 32'h28, RESP_OKAY);
    bus_wr(IDX_CTRL, 32'h30, RESP_SLVERR);
    bus_wr(IDX_CTRL, 32'h20, RESP_OKAY);
    rd_chk("preset gain", IDX_CVAL, 32'h55, RESP_OKAY);
    // calculation region bounds
    bus_wr(IDX_WB_WIDTH, 32'h0, RESP_SLVERR);
    bus_wr(IDX_WB_WIDTH, 32'h659, RESP_SLVERR);
    bus_wr(IDX_WB_WIDTH, 32'h1, RESP_OKAY);
    bus_wr(IDX_WB_HEIGHT, 32'h4d9, RESP_SLVERR);
    bus_wr(IDX_WB_LEFT, 32'h658, RESP_SLVERR);
    bus_wr(IDX_WB_LEFT, 32'h657, RESP_OKAY);
    bus_wr(IDX_WB_TOP, 32'h4d8, RESP_SLVERR);
    bus_wr(IDX_WB_TOP, 32'h4d7, RESP_OKAY);
    chk("region pos", {10'h0, 11'h657, 11'h4d7},
        {10'h0, wbr.left, wbr.top});
    chk("region size", {10'h0, 11'h001, 11'h4d8},
        {10'h0, wbr.width, wbr.height});
    // only the strobed low lane lands; the high lanes would be out of range
    bus_wr(IDX_WB_LEFT, 32'hffff_ff12, RESP_OKAY, 4'h1);
    chk("merged left", 32'h612, {21'h0, wbr.left});
    // unmapped and read-only places
    rd_chk("unmapped", 6'h0f, 32'h0, RESP_SLVERR);
    bus_wr(IDX_STATUS, 32'h0, RESP_SLVERR);
    end_of_test();
  end

endmodule : tb
